/* File: src/pcdio_device.sv */
`timescale 1ns/1ps
`include "pcdio_regs.svh"
// Overview of operation
// RL1 - eight data pins, each with direction bit
// RL2 - slave select bit turns port into slave
// RL3 - low control pins become read, write, select
// RL4 - software sets control pins digital inputs first
// RL5 - analog control pins read back zero
// RL6 - direction bits drive pins even when analog
// RL7 - control pins analog after reset
// RL8 - input only pin needs reset pin disabled
// RL9 - dummy direction bit reads one, ignored
// RL10 - host read drives data onto pins
// RL11 - host write latches pins into register
// RL12 - select active low gates strobes
// RL13 - port directions reset to all inputs
// RL14 - direction one tristates, zero drives latch
// RL15 - input pending flag tracks unread word
// RL16 - sticky overrun on write while pending
// RL17 - output pending until host reads
// RL18 - strobes synchronised before use
// RL19 - clearing slave mode restores plain I/O
module pcdio_device (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // software register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // configuration straps
  input  wire logic       reset_pin_enable,
  // serial side port pins
  input  wire logic [7:0] c_pin_in,
  output logic      [7:0] c_pin_out,
  output logic      [7:0] c_pin_oe,
  // input only pin
  input  wire logic       input_only_pin,
  // link
  pcdio_if.device         link
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] c_lat;
    logic [7:0] d_lat;
    logic [7:0] d_in;
    logic [2:0] e_lat;
    logic [7:0] c_dir;
    logic [7:0] d_dir;
    logic [2:0] e_dir;
    logic       slave;
    logic       in_pend;
    logic       out_pend;
    logic       overrun;
    logic [3:0] ansel;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [7:0] rdata;
    logic [7:0] c_out;
    logic [7:0] c_oe;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [2:0] e_out;
    logic [2:0] e_oe;
  } pcdio_dev_state_t;

  pcdio_dev_state_t r;
  pcdio_dev_state_t next_r;

  logic [2:0] e_pins;
  logic [7:0] d_pins;
  logic       digital;
  logic       rd_act;
  logic       rd_act_q;
  logic       wr_act;
  logic       wr_act_q;

  function automatic logic [7:0] pcdio_pin(input logic [7:0] own, input logic [7:0] oe,
                                           input logic [7:0] ext);
    pcdio_pin = (own & oe) | (ext & ~oe);
  endfunction

  function automatic logic pcdio_active(input logic slave, input logic sel_n,
                                        input logic stb_n);
    pcdio_active = slave && !sel_n && !stb_n;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r  = r;
    d_pins  = pcdio_pin(r.d_out, r.d_oe, link.d_host_oe ? link.d_from_host : 8'h00);
    e_pins  = link.e_host_oe ? link.e_from_host : r.e_out;
    digital = (r.ansel >= `PCDIO_ANSEL_DIGITAL);
    // ----------------------------------------
    // host strobes
    // ----------------------------------------
    // bit0 read, bit1 write, bit2 select, all active low
    next_r.s1 = e_pins; // RL18
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    rd_act    = pcdio_active(r.slave, r.s2[2], r.s2[0]); // RL10 RL12
    rd_act_q  = pcdio_active(r.slave, r.s3[2], r.s3[0]);
    wr_act    = pcdio_active(r.slave, r.s2[2], r.s2[1]); // RL11 RL12
    wr_act_q  = pcdio_active(r.slave, r.s3[2], r.s3[1]);
    // data latched while write strobe active
    if (wr_act) begin
      next_r.d_in = d_pins; // RL11
    end
    if (!rd_act && rd_act_q) begin
      next_r.out_pend = 1'b0; // RL17
    end
    // ----------------------------------------
    // software side
    // ----------------------------------------
    if (reg_rd && reg_addr == `PCDIO_OFS_D_DATA) begin
      next_r.in_pend = 1'b0; // RL15
    end
    if (reg_wr) begin
      case (reg_addr)
        `PCDIO_OFS_C_DATA: next_r.c_lat = reg_wdata;
        `PCDIO_OFS_D_DATA: begin
          next_r.d_lat = reg_wdata;
          if (r.slave) begin
            next_r.out_pend = 1'b1; // RL17
          end
        end
        `PCDIO_OFS_E_DATA: next_r.e_lat = reg_wdata[2:0];
        `PCDIO_OFS_C_DIR:  next_r.c_dir = reg_wdata;
        `PCDIO_OFS_D_DIR:  next_r.d_dir = reg_wdata;
        `PCDIO_OFS_E_DIR: begin
          next_r.e_dir   = reg_wdata[2:0]; // RL9
          next_r.slave   = reg_wdata[`PCDIO_BIT_SLAVE]; // RL2 RL19
          next_r.overrun = r.overrun & reg_wdata[`PCDIO_BIT_OVERRUN]; // RL16
        end
        `PCDIO_OFS_ANSEL:  next_r.ansel = reg_wdata[3:0];
        default: begin
        end
      endcase
    end
    if (!wr_act && wr_act_q) begin
      next_r.in_pend = 1'b1; // RL15
      if (r.in_pend) begin
        next_r.overrun = 1'b1; // RL16
      end
    end
    // ----------------------------------------
    // read data
    // ----------------------------------------
    case (reg_addr)
      `PCDIO_OFS_C_DATA: next_r.rdata = pcdio_pin(r.c_out, r.c_oe, c_pin_in);
      `PCDIO_OFS_D_DATA: next_r.rdata = r.slave ? r.d_in : d_pins;
      `PCDIO_OFS_E_DATA: next_r.rdata = {4'h0,
                                        input_only_pin & ~reset_pin_enable, // RL8
                                        digital ? e_pins : 3'h0}; // RL5 RL7
      `PCDIO_OFS_C_DIR:  next_r.rdata = r.c_dir;
      `PCDIO_OFS_D_DIR:  next_r.rdata = r.d_dir;
      `PCDIO_OFS_E_DIR:  next_r.rdata = {r.in_pend, r.out_pend, r.overrun, r.slave,
                                        1'b1, r.e_dir}; // RL9
      `PCDIO_OFS_ANSEL:  next_r.rdata = {4'h0, r.ansel};
      default:           next_r.rdata = 8'h00;
    endcase
    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    next_r.c_out = r.c_lat;
    next_r.c_oe  = ~r.c_dir; // RL14
    next_r.e_out = r.e_lat;
    next_r.e_oe  = ~r.e_dir; // RL6
    if (r.slave) begin
      next_r.d_out = r.d_lat;
      next_r.d_oe  = rd_act ? 8'hFF : 8'h00; // RL10
    end else begin
      next_r.d_out = r.d_lat; // RL1 RL19
      next_r.d_oe  = ~r.d_dir; // RL14
    end
    // ----------------------------------------
    // reset
    // ----------------------------------------
    if (rst) begin
      next_r          = '0;
      next_r.c_dir    = `PCDIO_RST_DIR; // RL13
      next_r.d_dir    = `PCDIO_RST_DIR; // RL13
      next_r.e_dir    = 3'(`PCDIO_RST_E_DIR);
      next_r.ansel    = 4'(`PCDIO_RST_ANSEL); // RL7
      next_r.s1       = 3'h7;
      next_r.s2       = 3'h7;
      next_r.s3       = 3'h7;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= next_r;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata       = r.rdata;
  assign c_pin_out       = r.c_out;
  assign c_pin_oe        = r.c_oe;
  assign link.d_from_dev = r.d_out;
  assign link.d_dev_oe   = r.d_oe;
  assign link.e_from_dev = r.e_out;
  assign link.e_dev_oe   = r.e_oe; // RL3
endmodule // pcdio_device

/* File: src/pcdio_regs.svh */
`ifndef PCDIO_REGS_SVH
`define PCDIO_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCDIO_OFS_C_DATA   8'h07
`define PCDIO_OFS_D_DATA   8'h08
`define PCDIO_OFS_E_DATA   8'h09
`define PCDIO_OFS_C_DIR    8'h87
`define PCDIO_OFS_D_DIR    8'h88
`define PCDIO_OFS_E_DIR    8'h89
`define PCDIO_OFS_ANSEL    8'h9F
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define PCDIO_RST_DIR      8'hFF
`define PCDIO_RST_E_DIR    8'h0F
`define PCDIO_RST_ANSEL    8'h00
`define PCDIO_BIT_IN_PEND  7
`define PCDIO_BIT_OUT_PEND 6
`define PCDIO_BIT_OVERRUN  5
`define PCDIO_BIT_SLAVE    4
`define PCDIO_BIT_DUMMY    3
// analog config value at or above which control side pins are digital
`define PCDIO_ANSEL_DIGITAL 4'h7
`define PCDIO_HOST_HOLD    4'h4
`endif

/* File: src/pcdio_pkg.sv */
package pcdio_pkg;
  typedef enum logic [1:0] {
    PCDIO_H_IDLE,
    PCDIO_H_ASSERT,
    PCDIO_H_RELEASE
  } pcdio_host_state_t;
  typedef enum logic [1:0] {
    PCDIO_CMD_NONE,
    PCDIO_CMD_READ,
    PCDIO_CMD_WRITE
  } pcdio_cmd_t;
endpackage

/* File: src/pcdio_if.sv */
`timescale 1ns/1ps
interface pcdio_if;
  // parallel data pins
  logic [7:0] d_from_dev;
  logic [7:0] d_dev_oe;
  logic [7:0] d_from_host;
  logic       d_host_oe;
  // control side pins 2:0 (read, write, select), driven by host
  logic [2:0] e_from_dev;
  logic [2:0] e_dev_oe;
  logic [2:0] e_from_host;
  logic       e_host_oe;
  modport device (
    output d_from_dev, d_dev_oe, e_from_dev, e_dev_oe,
    input  d_from_host, d_host_oe, e_from_host, e_host_oe
  );
  modport host (
    input  d_from_dev, d_dev_oe, e_from_dev, e_dev_oe,
    output d_from_host, d_host_oe, e_from_host, e_host_oe
  );
endinterface

/* File: src/pcdio_host.sv */
`timescale 1ns/1ps
`include "pcdio_regs.svh"
module pcdio_host (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // user command port
  input  wire pcdio_pkg::pcdio_cmd_t cmd,
  input  wire logic [7:0]         cmd_wdata,
  output logic                    cmd_busy,
  output logic                    cmd_done,
  output logic      [7:0]         cmd_rdata,
  // link
  pcdio_if.host                   link
);
  typedef struct packed {
    pcdio_pkg::pcdio_host_state_t st;
    pcdio_pkg::pcdio_cmd_t        op;
    logic [3:0]                   cnt;
    logic [7:0]                   wdata;
    logic [7:0]                   rdata;
    logic [2:0]                   ctl;
    logic                         d_oe;
    logic                         busy;
    logic                         done;
  } pcdio_host_s_t;

  pcdio_host_s_t r;
  pcdio_host_s_t next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.st)
      pcdio_pkg::PCDIO_H_IDLE: begin
        next_r.ctl  = 3'h7;
        next_r.d_oe = 1'b0;
        if (cmd != pcdio_pkg::PCDIO_CMD_NONE) begin
          next_r.op    = cmd;
          next_r.wdata = cmd_wdata;
          next_r.busy  = 1'b1;
          next_r.cnt   = `PCDIO_HOST_HOLD;
          next_r.st    = pcdio_pkg::PCDIO_H_ASSERT;
          // select low with read or write low
          next_r.ctl   = (cmd == pcdio_pkg::PCDIO_CMD_READ) ? 3'h2 : 3'h1; // RL10 RL11 RL12
          next_r.d_oe  = (cmd == pcdio_pkg::PCDIO_CMD_WRITE);
        end
      end
      pcdio_pkg::PCDIO_H_ASSERT: begin
        next_r.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h1) begin
          if (r.op == pcdio_pkg::PCDIO_CMD_READ) begin
            next_r.rdata = link.d_from_dev & link.d_dev_oe;
          end
          next_r.ctl = 3'h7;
          next_r.cnt = `PCDIO_HOST_HOLD;
          next_r.st  = pcdio_pkg::PCDIO_H_RELEASE;
        end
      end
      pcdio_pkg::PCDIO_H_RELEASE: begin
        next_r.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h1) begin
          next_r.d_oe = 1'b0;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st   = pcdio_pkg::PCDIO_H_IDLE;
        end
      end
      default: next_r.st = pcdio_pkg::PCDIO_H_IDLE;
    endcase
    if (rst) begin
      next_r     = '0;
      next_r.ctl = 3'h7;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= next_r;
  end

  assign cmd_busy         = r.busy;
  assign cmd_done         = r.done;
  assign cmd_rdata        = r.rdata;
  assign link.d_from_host = r.wdata;
  assign link.d_host_oe   = r.d_oe;
  assign link.e_from_host = r.ctl;
  assign link.e_host_oe   = 1'b1;
endmodule // pcdio_host

/* File: verif/pcdio_monitor.sv */
`timescale 1ns/1ps
module pcdio_monitor (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // link signals
  input wire logic [7:0] d_from_dev,
  input wire logic [7:0] d_dev_oe,
  input wire logic       d_host_oe,
  input wire logic [2:0] e_dev_oe,
  input wire logic [2:0] e_from_host
);
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rst_quiet;
    $fell(rst) |-> d_dev_oe == 8'h00 && e_dev_oe == 3'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("drive active after reset");
  property p_one_strobe;
    e_from_host[1:0] != 2'b00;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_sel_strobe;
    e_from_host[1:0] != 2'b11 |-> !e_from_host[2];
  endproperty
  a_sel_strobe: assert property (p_sel_strobe) else $error("strobe without select");
  property p_wr_hold;
    $fell(e_from_host[1]) |-> !e_from_host[1] [*4] ##1 e_from_host[1];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write strobe length wrong");
  property p_rd_hold;
    $fell(e_from_host[0]) |-> !e_from_host[0] [*4] ##1 e_from_host[0];
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read strobe length wrong");
  property p_no_fight;
    !(d_host_oe && d_dev_oe != 8'h00);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data bus driven by both");
  property p_rd_drive;
    $changed(d_dev_oe) && !e_from_host[0] |-> d_dev_oe == 8'hFF;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("partial drive on read");
  property p_rd_stable;
    d_dev_oe == 8'hFF && $past(d_dev_oe) == 8'hFF |-> $stable(d_from_dev);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  property p_ctl_input;
    e_from_host[1:0] != 2'b11 |-> e_dev_oe == 3'h0;
  endproperty
  a_ctl_input: assert property (p_ctl_input) else $error("control pin driven");
endmodule // pcdio_monitor

/* File: verif/port_cde_io_with_parallel_slave_test.sv */
`timescale 1ns/1ps
`include "pcdio_regs.svh"
module port_cde_io_with_parallel_slave_test;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  logic       core_clk = 1'b0;
  logic       rst, reg_wr, reg_rd, reset_pin_enable, input_only_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, c_pin_in, c_pin_out, c_pin_oe;
  logic [7:0] cmd_wdata, cmd_rdata, v, w;
  logic       cmd_busy, cmd_done;
  int         err_total = 0, checks = 0, i, seed;
  pcdio_pkg::pcdio_cmd_t cmd;
  pcdio_if pcdio_if_i ();
  pcdio_device pcdio_device_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reset_pin_enable(reset_pin_enable), .c_pin_in(c_pin_in), .c_pin_out(c_pin_out),
    .c_pin_oe(c_pin_oe), .input_only_pin(input_only_pin), .link(pcdio_if_i));
  pcdio_host pcdio_host_i (.core_clk(core_clk), .rst(rst), .cmd(cmd), .cmd_wdata(cmd_wdata),
    .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata), .link(pcdio_if_i));
  pcdio_monitor pcdio_monitor_i (.core_clk(core_clk), .rst(rst),
    .d_from_dev(pcdio_if_i.d_from_dev), .d_dev_oe(pcdio_if_i.d_dev_oe),
    .d_host_oe(pcdio_if_i.d_host_oe), .e_dev_oe(pcdio_if_i.e_dev_oe),
    .e_from_host(pcdio_if_i.e_from_host));
  always #2.5 core_clk = ~core_clk;

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk); reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge core_clk); reg_wr = 1'b0;
  endtask
  task automatic chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk); reg_addr = a; reg_rd = 1'b1;
    @(negedge core_clk); reg_rd = 1'b0;
    @(negedge core_clk); cmp8(what, exp, reg_rdata);
  endtask
  task automatic host(input pcdio_pkg::pcdio_cmd_t c, input logic [7:0] d);
    int n;
    @(negedge core_clk); cmd = c; cmd_wdata = d;
    @(negedge core_clk); cmd = pcdio_pkg::PCDIO_CMD_NONE;
    cmp8("busy", 8'h01, {7'h00, cmd_busy});
    n = 0;
    while (cmd_done !== 1'b1 && n < 50) begin
      @(negedge core_clk); n++;
    end
    if (n == 50) begin
      err_total++;
      $display("Error host done expected 1 seen 0");
    end
    cmp8("idle", 8'h00, {7'h00, cmd_busy});
    repeat (6) @(negedge core_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000; err_total++; wrap_up();
  end
  initial begin
    seed = 32'h39adae02;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    reset_pin_enable = 1'b1; input_only_pin = 1'b1; c_pin_in = $random(seed);
    cmd = pcdio_pkg::PCDIO_CMD_NONE; cmd_wdata = 8'h00;
    repeat (20) @(negedge core_clk); rst = 1'b0;
    chk("c_dir", `PCDIO_OFS_C_DIR, 8'hFF);
    chk("d_dir", `PCDIO_OFS_D_DIR, 8'hFF);
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'h0F);
    chk("e_data", `PCDIO_OFS_E_DATA, 8'h00);
    chk("unmapped", 8'h55, 8'h00);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      v = $random(seed); w = $random(seed);
      c_pin_in = $random(seed);
      wr(`PCDIO_OFS_C_DATA, w); wr(`PCDIO_OFS_C_DIR, v); wr(`PCDIO_OFS_D_DIR, v);
      @(negedge core_clk);
      cmp8("c_oe", ~v, c_pin_oe);
      cmp8("c_out", w & ~v, c_pin_out & ~v);
      cmp8("d_oe", ~v, pcdio_if_i.d_dev_oe);
      chk("c_data", `PCDIO_OFS_C_DATA, (w & ~v) | (c_pin_in & v));
    end
    $display("direction test done");
    wr(`PCDIO_OFS_E_DATA, w);
    wr(`PCDIO_OFS_E_DIR, 8'h00); @(negedge core_clk);
    cmp8("e_oe", 8'h07, {5'h00, pcdio_if_i.e_dev_oe});
    cmp8("e_out", {5'h00, w[2:0]}, {5'h00, pcdio_if_i.e_from_dev});
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'h08);
    chk("e_data", `PCDIO_OFS_E_DATA, 8'h00);
    wr(`PCDIO_OFS_ANSEL, 8'h07); wr(`PCDIO_OFS_E_DIR, 8'h07); reset_pin_enable = 1'b0;
    chk("e_data", `PCDIO_OFS_E_DATA, 8'h0F);
    reset_pin_enable = 1'b1;
    chk("e_data", `PCDIO_OFS_E_DATA, 8'h07);
    $display("control side test done");
    wr(`PCDIO_OFS_D_DIR, 8'hFF); wr(`PCDIO_OFS_E_DIR, 8'h17);
    for (i = 0; i < 3; i++) begin
      w = $random(seed); host(pcdio_pkg::PCDIO_CMD_WRITE, w);
      chk("e_dir", `PCDIO_OFS_E_DIR, 8'h9F);
      chk("d_data", `PCDIO_OFS_D_DATA, w);
      chk("e_dir", `PCDIO_OFS_E_DIR, 8'h1F);
    end
    host(pcdio_pkg::PCDIO_CMD_WRITE, 8'h00); host(pcdio_pkg::PCDIO_CMD_WRITE, w);
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'hBF);
    wr(`PCDIO_OFS_E_DIR, 8'h17);
    chk("d_data", `PCDIO_OFS_D_DATA, w);
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'h1F);
    v = $random(seed); wr(`PCDIO_OFS_D_DATA, v);
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'h5F);
    host(pcdio_pkg::PCDIO_CMD_READ, 8'h00);
    cmp8("host_rd", v, cmd_rdata);
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'h1F);
    $display("slave port test done");
    wr(`PCDIO_OFS_E_DIR, 8'h07);
    host(pcdio_pkg::PCDIO_CMD_WRITE, 8'hA5);
    chk("e_dir", `PCDIO_OFS_E_DIR, 8'h0F);
    wr(`PCDIO_OFS_D_DATA, w); wr(`PCDIO_OFS_D_DIR, 8'h00);
    repeat (2) @(negedge core_clk);
    cmp8("d_oe", 8'hFF, pcdio_if_i.d_dev_oe);
    cmp8("d_out", w, pcdio_if_i.d_from_dev);
    chk("d_data", `PCDIO_OFS_D_DATA, w);
    rst = 1'b1; repeat (2) @(negedge core_clk); rst = 1'b0;
    chk("d_dir", `PCDIO_OFS_D_DIR, 8'hFF);
    $display("plain io test done");
    wrap_up();
  end
endmodule // port_cde_io_with_parallel_slave_test
